/* sar_cfg_pkg.sv */
package sar_cfg_pkg;
    localparam logic [7:0] ADC_CONFIG_OFFSET = 8'hbc;
    localparam logic [7:0] ADC_CONFIG_RESET = 8'hf8;
    localparam int DIV_LSB = 3;
    localparam int DIV_MSB = 7;
    localparam int LOW_RES_BIT = 2;
    localparam int TRACK_BIT = 1;
    localparam int GAIN_BIT = 0;
    localparam logic [7:0] STATUS_OFFSET = 8'hc0;
    localparam logic [7:0] CONTROL_OFFSET = 8'hc4;
    localparam int BURST_BIT = 0;
    localparam int DELAY_TRACK_CYCLES = 3;
    localparam int FULL_RES_BITS = 10;
    localparam int LOW_RES_BITS = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_e;
endpackage : sar_cfg_pkg

/* clk_div_if.sv */
`timescale 1ns/1ps
interface clk_div_if;
    logic [4:0] divider;
    logic sourceTick;
    logic convTick;
    logic convClk;
    modport master (output divider, output sourceTick, input convTick, input convClk);
    modport divider_side (input divider, input sourceTick, output convTick, output convClk);
endinterface : clk_div_if

/* conv_clk_divider.sv */
`timescale 1ns/1ps
module conv_clk_divider
    import sar_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    clk_div_if.divider_side dv
);
    logic [4:0] count_r;
    logic [4:0] count_nxt;
    logic clk_r;
    logic clk_nxt;
    logic tick;

    always_comb begin
        count_nxt = count_r;
        clk_nxt = clk_r;
        tick = 1'b0;
        if (dv.sourceTick) begin
            if (count_r >= dv.divider) begin
                count_nxt = 5'h00;
                tick = 1'b1;
                clk_nxt = 1'b1;
            end else begin
                count_nxt = count_r + 5'h01;
                // six bits, so that a divider of 31 does not wrap to zero
                clk_nxt = ({1'b0, count_r} + 6'h01) < (({1'b0, dv.divider} + 6'h01) >> 1) ? 1'b1 : 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_r <= 5'h00;
            clk_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign dv.convTick = tick;
    assign dv.convClk = clk_r;

    // period check
    property tick_period_p;
        @(posedge clock) disable iff (rst)
        dv.convTick |=> (count_r == 5'h00 && clk_r);
    endproperty
    tick_period_a: assert property (tick_period_p)
        else $error("divider count not restarted after tick");
endmodule : conv_clk_divider

/* sar_adc_config_control.sv */
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module sar_adc_config_control
    import sar_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic lowPowerOscTick,
    input wire logic startConversion,
    input wire logic converterEnable,
    input wire logic conversionDone,
    output logic conversionClk,
    output logic conversionClkTick,
    output logic trackActive,
    output logic convertActive,
    output logic lowResEnable,
    output logic [3:0] resultBits,
    output logic ampGainSelect
);
    logic [7:0] config_r;
    logic [7:0] config_nxt;
    logic burst_r;
    logic burst_nxt;
    logic awHeld_r;
    logic awHeld_nxt;
    logic [7:0] awAddr_r;
    logic [7:0] awAddr_nxt;
    logic wHeld_r;
    logic wHeld_nxt;
    logic [7:0] wData_r;
    logic [7:0] wData_nxt;
    logic wStrb_r;
    logic wStrb_nxt;
    logic bValid_r;
    logic bValid_nxt;
    logic [1:0] bResp_r;
    logic [1:0] bResp_nxt;
    logic rValid_r;
    logic rValid_nxt;
    logic [31:0] rData_r;
    logic [31:0] rData_nxt;
    logic [1:0] rResp_r;
    logic [1:0] rResp_nxt;
    conv_state_e state_r;
    conv_state_e state_nxt;
    logic [1:0] delay_r;
    logic [1:0] delay_nxt;
    logic [4:0] divider;
    clk_div_if dvBus ();

    assign s_axi_awready = !awHeld_r && !bValid_r;
    assign s_axi_wready = !wHeld_r && !bValid_r;
    assign s_axi_arready = !rValid_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;

    // register write and read paths
    always_comb begin
        logic [7:0] wa;
        logic [7:0] wd;
        logic ws;
        logic haveAw;
        logic haveW;
        awHeld_nxt = awHeld_r;
        awAddr_nxt = awAddr_r;
        wHeld_nxt = wHeld_r;
        wData_nxt = wData_r;
        wStrb_nxt = wStrb_r;
        bValid_nxt = bValid_r;
        bResp_nxt = bResp_r;
        rValid_nxt = rValid_r;
        rData_nxt = rData_r;
        rResp_nxt = rResp_r;
        config_nxt = config_r;
        burst_nxt = burst_r;
        haveAw = awHeld_r || (s_axi_awvalid && s_axi_awready);
        haveW = wHeld_r || (s_axi_wvalid && s_axi_wready);
        wa = awHeld_r ? awAddr_r : s_axi_awaddr;
        wd = wHeld_r ? wData_r : s_axi_wdata[7:0];
        ws = wHeld_r ? wStrb_r : s_axi_wstrb[0];
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_nxt = 1'b1;
            awAddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_nxt = 1'b1;
            wData_nxt = s_axi_wdata[7:0];
            wStrb_nxt = s_axi_wstrb[0];
        end
        if (haveAw && haveW && !bValid_r) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt = RESP_OKAY;
            if (wa == ADC_CONFIG_OFFSET) begin
                if (ws) begin
                    config_nxt = wd;
                end
            end else if (wa == CONTROL_OFFSET) begin
                if (ws) begin
                    burst_nxt = wd[BURST_BIT];
                end
            end else if (wa != STATUS_OFFSET) begin
                bResp_nxt = RESP_SLVERR;
            end
        end
        if (bValid_r && s_axi_bready) begin
            bValid_nxt = 1'b0;
        end
        if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_nxt = 1'b1;
            rResp_nxt = RESP_OKAY;
            rData_nxt = 32'h00000000;
            case (s_axi_araddr)
                ADC_CONFIG_OFFSET: rData_nxt = {24'h000000, config_r};
                CONTROL_OFFSET: rData_nxt = {31'h00000000, burst_r};
                STATUS_OFFSET: rData_nxt = {28'h0000000, delay_r, state_r};
                default: rResp_nxt = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wHeld_r <= 1'b0;
            wData_r <= 8'h00;
            wStrb_r <= 1'b0;
            bValid_r <= 1'b0;
            bResp_r <= 2'h0;
            rValid_r <= 1'b0;
            rData_r <= 32'h00000000;
            rResp_r <= 2'h0;
            config_r <= ADC_CONFIG_RESET;
            burst_r <= 1'b0;
        end else begin
            awHeld_r <= awHeld_nxt;
            awAddr_r <= awAddr_nxt;
            wHeld_r <= wHeld_nxt;
            wData_r <= wData_nxt;
            wStrb_r <= wStrb_nxt;
            bValid_r <= bValid_nxt;
            bResp_r <= bResp_nxt;
            rValid_r <= rValid_nxt;
            rData_r <= rData_nxt;
            rResp_r <= rResp_nxt;
            config_r <= config_nxt;
            burst_r <= burst_nxt;
        end
    end

    assign divider = config_r[DIV_MSB:DIV_LSB];
    assign dvBus.divider = divider;
    assign dvBus.sourceTick = burst_r ? lowPowerOscTick : 1'b1;

    conv_clk_divider divUnit (
        .clock(clock),
        .rst(rst),
        .dv(dvBus.divider_side)
    );

    assign conversionClk = dvBus.convClk;
    assign conversionClkTick = dvBus.convTick;

    always_comb begin
        state_nxt = state_r;
        delay_nxt = delay_r;
        case (state_r)
            ST_IDLE: begin
                if (startConversion && converterEnable) begin
                    if (config_r[TRACK_BIT]) begin
                        state_nxt = ST_TRACK;
                        delay_nxt = 2'h0;
                    end else begin
                        state_nxt = ST_CONVERT;
                    end
                end
            end
            ST_TRACK: begin
                if (dvBus.convTick) begin
                    if (delay_r == 2'(DELAY_TRACK_CYCLES - 1)) begin
                        state_nxt = ST_CONVERT;
                    end else begin
                        delay_nxt = delay_r + 2'h1;
                    end
                end
            end
            ST_CONVERT: begin
                if (conversionDone) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (!converterEnable) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= ST_IDLE;
            delay_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            delay_r <= delay_nxt;
        end
    end

    assign trackActive = (state_r != ST_CONVERT);
    assign convertActive = (state_r == ST_CONVERT);
    assign lowResEnable = config_r[LOW_RES_BIT];
    assign resultBits = config_r[LOW_RES_BIT] ? 4'(LOW_RES_BITS) : 4'(FULL_RES_BITS);
    assign ampGainSelect = config_r[GAIN_BIT];

    normal_start_a: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_IDLE && startConversion && converterEnable && !config_r[TRACK_BIT])
        |=> convertActive)
        else $error("normal track did not convert next cycle");
    delayed_start_a: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_IDLE && startConversion && converterEnable && config_r[TRACK_BIT])
        |=> !convertActive)
        else $error("delayed track converted too early");
    track_hold_a: assert property (@(posedge clock) disable iff (rst)
        (state_r == ST_TRACK && !dvBus.convTick && converterEnable)
        |=> state_r == ST_TRACK && trackActive && !convertActive)
        else $error("not tracking during delay");
    res_select_a: assert property (@(posedge clock) disable iff (rst)
        lowResEnable |-> resultBits == 4'h8)
        else $error("low resolution width wrong");
    res_normal_a: assert property (@(posedge clock) disable iff (rst)
        !lowResEnable |-> resultBits == 4'ha)
        else $error("full resolution width wrong");
    burst_source_a: assert property (@(posedge clock) disable iff (rst)
        (burst_r && !lowPowerOscTick) |=> $stable(divUnit.count_r))
        else $error("divider advanced without oscillator tick");
    sys_source_a: assert property (@(posedge clock) disable iff (rst)
        (!burst_r && divider != 5'h00 && !dvBus.convTick) |=> divUnit.count_r != $past(divUnit.count_r))
        else $error("divider idle on system clock");
    gain_follow_a: assert property (@(posedge clock) disable iff (rst)
        ampGainSelect == config_r[GAIN_BIT])
        else $error("gain output mismatch");
endmodule : sar_adc_config_control

/* conv_core_model.sv */
`timescale 1ns/1ps
module conv_core_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic convertActive,
    input wire logic conversionClkTick,
    input wire logic [3:0] resultBits,
    output logic conversionDone
);
    logic [3:0] bitCnt_r;

    // one bit per tick
    // done is a single pulse; the count clears once convert drops
    always_ff @(posedge clock) begin
        conversionDone <= 1'b0;
        if (rst || !convertActive || conversionDone) begin
            bitCnt_r <= 4'h0;
        end else if (conversionClkTick) begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r + 4'h1 == resultBits) begin
                conversionDone <= 1'b1;
            end
        end
    end
endmodule : conv_core_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
    import sar_cfg_pkg::*;
    logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, lowPowerOscTick, startConversion, converterEnable;
    logic conversionDone, conversionClk, conversionClkTick, trackActive;
    logic convertActive, lowResEnable, ampGainSelect;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, resultBits;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int errors, cmp_count, p, k, h;
    int divs[3] = '{0, 2, 31};

    sar_adc_config_control dut (.*);
    conv_core_model core (.*);

    always #12.5 clock = ~clock;
    // oscillator pulse every other clock, a 20 MHz source
    always @(posedge clock) lowPowerOscTick <= ~lowPowerOscTick;

    task summarize;
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
            errors++;
        end
    endtask : chk

    task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw, w, b;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        n = 0;
        // ready is sampled mid-cycle, where it is settled for the coming edge
        while (!b && n < 100) begin
            @(negedge clock);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clock);
            n++;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
        if (!b) begin
            errors++;
            summarize();
        end
    endtask : axw

    task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ar, v;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        v = 1'b0;
        n = 0;
        while (!v && n < 100) begin
            @(negedge clock);
            ar = s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clock);
            n++;
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) s_axi_rready <= 1'b0;
        end
        if (!v) begin
            errors++;
            summarize();
        end
    endtask : axr

    task per(output int q);
        int n;
        n = 0;
        q = 0;
        h = 0;
        do begin @(negedge clock); n++; end while (conversionClkTick !== 1'b1 && n < 200);
        do begin
            @(negedge clock);
            q++;
            if (conversionClk === 1'b1) h++;
        end while (conversionClkTick !== 1'b1 && q < 200);
        if (q >= 200) begin
            errors++;
            summarize();
        end
    endtask : per

    task start;
        @(posedge clock) startConversion <= 1'b1;
        @(posedge clock) startConversion <= 1'b0;
    endtask : start

    task wait_idle;
        int n;
        n = 0;
        while (convertActive !== 1'b0 && n < 300) begin @(negedge clock); n++; end
        if (n >= 300) begin
            errors++;
            summarize();
        end
    endtask : wait_idle

    initial begin
        {clock, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, lowPowerOscTick, startConversion} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        converterEnable = 1'b1;
        rst = 1'b1;
        errors = 0;
        cmp_count = 0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        axr(ADC_CONFIG_OFFSET, rd, resp);
        chk("reset cfg", rd[7:0], ADC_CONFIG_RESET);
        chk("reset bits", resultBits, FULL_RES_BITS);
        chk("reset low res", lowResEnable, 0);
        $display("test reset done");
        axw(ADC_CONFIG_OFFSET, 32'h15, resp);
        axr(ADC_CONFIG_OFFSET, rd, resp);
        chk("cfg", rd[7:0], 8'h15);
        chk("low res", lowResEnable, 1);
        chk("bits", resultBits, LOW_RES_BITS);
        chk("gain", ampGainSelect, 1);
        axw(8'hd0, 32'hff, resp);
        chk("bad wr resp", resp, RESP_SLVERR);
        axr(8'hd0, rd, resp);
        chk("bad rd resp", resp, RESP_SLVERR);
        axr(ADC_CONFIG_OFFSET, rd, resp);
        chk("cfg kept", rd[7:0], 8'h15);
        $display("test config done");
        foreach (divs[i]) begin
            axw(ADC_CONFIG_OFFSET, 32'(divs[i]) << 3, resp);
            per(p);
            per(p);
            chk("period", 32'(p), 32'(divs[i] + 1));
            if (divs[i] == 31) chk("clk high", 32'(h), 32'd16);
        end
        axw(CONTROL_OFFSET, 32'h1, resp);
        per(p);
        per(p);
        chk("burst period", 32'(p), 32'd64);
        chk("burst clk high", 32'(h), 32'd32);
        axw(CONTROL_OFFSET, 32'h0, resp);
        $display("test divider done");
        axw(ADC_CONFIG_OFFSET, 32'h10, resp);
        @(posedge clock) converterEnable <= 1'b0;
        start();
        @(negedge clock);
        chk("disabled", convertActive, 0);
        @(posedge clock) converterEnable <= 1'b1;
        start();
        @(negedge clock);
        chk("convert", convertActive, 1);
        chk("track off", trackActive, 0);
        wait_idle();
        axw(ADC_CONFIG_OFFSET, 32'h12, resp);
        start();
        k = 0;
        for (int n = 0; n < 300 && convertActive !== 1'b1; n++) begin
            @(negedge clock);
            if (convertActive !== 1'b1) begin
                if (conversionClkTick) k++;
                chk("tracking", trackActive, 1);
            end
        end
        if (convertActive !== 1'b1) begin
            errors++;
            summarize();
        end
        chk("delay ticks", 32'(k), 32'(DELAY_TRACK_CYCLES));
        wait_idle();
        $display("test conversion done");
        summarize();
    end
endmodule : testbench
